// ---- shared/irq_flags_pkg.sv ----
// package: register map, field layout and carriers for the external request flags block
package irq_flags_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] flags_off      = 8'h00;  // external_request_flags
  localparam logic [7:0] sense_off      = 8'h04;  // request pin sense select
  localparam logic [7:0] port_sense_off = 8'h08;  // port pin sense select
  localparam logic [7:0] port_en_off    = 8'h0c;  // port pin enable
  localparam logic [7:0] int_stat_off   = 8'h10;  // sticky event status
  localparam logic [7:0] int_mask_off   = 8'h14;  // event mask

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int          num_req       = 6;
  localparam int          num_port      = 16;
  localparam int          group_lo_bit  = 7;
  localparam int          group_hi_bit  = 6;
  localparam logic [7:0]  flags_rst     = 8'h00;
  localparam logic [11:0] sense_rst     = 12'h000;
  localparam logic [15:0] port_rst      = 16'h0000;
  localparam logic [7:0]  int_rst       = 8'h00;
  localparam logic [1:0]  resp_okay     = 2'b00;
  localparam logic [1:0]  resp_slverr   = 2'b10;

  // sense select encodings per request pin
  typedef enum logic [1:0] {
    sense_fall = 2'b00,
    sense_rise = 2'b01,
    sense_low  = 2'b10,
    sense_high = 2'b11
  } sense_mode_t;

  // port pin configuration travelling together
  typedef struct packed {
    logic [15:0] sense;
    logic [15:0] enable;
  } port_cfg_t;

  // one write taken from the bus
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } reg_write_t;

endpackage

// ---- core/pin_sync.sv ----
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter int width = 22
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [width-1:0] pin_in,
  output logic      [width-1:0] pin_out
);

  logic [width-1:0] meta_r;
  logic [width-1:0] meta_nxt;
  logic [width-1:0] stable_r;
  logic [width-1:0] stable_nxt;

  // next values: first stage only feeds the second
  always_comb begin
    meta_nxt   = pin_in;
    stable_nxt = meta_r;
  end

  // register both stages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r   <= '0;
      stable_r <= '0;
    end else begin
      meta_r   <= meta_nxt;
      stable_r <= stable_nxt;
    end
  end

  assign pin_out = stable_r;

endmodule

// ---- core/external_irq_request_flags.sv ----
// external interrupt request flag register with axi4-lite slave and interrupt output
//
// Overview of operation
// R1 - an eight-bit request flag register comes out of reset as all zero.
// R2 - bit 7 is read-only and shows 1 while any of port pins 0 to 7 requests.
// R3 - bit 6 is read-only and shows 1 while any of port pins 8 to 15 requests.
// R4 - bits 5 to 0 are read/write and bit n holds the pending state of request pin n.
// R5 - in edge mode a flag latches on the chosen edge and is cleared by writing 0 after reading it as 1.
// R6 - in level mode a flag follows the pin directly and software writes do not change it.
// R7 - each request pin has a two-bit sense select: 00 fall, 01 rise, 10 low, 11 high, upper bit odd.
// R8 - each of sixteen port pins has a sense bit choosing low or high level as its request.
// R9 - each of sixteen port pins has an enable bit and requests only count while it is 1.
// R10 - each group flag is the or of its eight pins after sense and enable gating.
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module external_irq_request_flags
  import irq_flags_pkg::*;
#(
  parameter int addr_width = 8
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [addr_width-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [addr_width-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [num_req-1:0]    request_pin,
  input  wire logic [num_port-1:0]   port_interrupt_pins,
  output logic                       irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [5:0]        req_flag_r, req_flag_nxt;
  logic [11:0]       sense_r, sense_nxt;
  port_cfg_t         port_cfg_r, port_cfg_nxt;
  logic [7:0]        int_stat_r, int_stat_nxt;
  logic [7:0]        int_mask_r, int_mask_nxt;
  logic [5:0]        seen_one_r, seen_one_nxt;
  logic [5:0]        pin_prev_r, pin_prev_nxt;
  logic              aw_held_r, aw_held_nxt;
  logic              w_held_r, w_held_nxt;
  logic [7:0]        aw_addr_r, aw_addr_nxt;
  logic [31:0]       w_data_r, w_data_nxt;
  logic [3:0]        w_strb_r, w_strb_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic [1:0]        rresp_r, rresp_nxt;
  logic [7:0]        flags_prev_r, flags_prev_nxt;

  logic [21:0]       pins_sync;
  logic [5:0]        req_pin_s;
  logic [15:0]       port_pin_s;
  logic [15:0]       port_req;
  logic              group_lo;
  logic              group_hi;
  logic [7:0]        flags_view;
  reg_write_t        wr;
  logic              rd_take;
  logic [15:0]       sense_wide;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  pin_sync #(
    .width(num_req + num_port)
  ) u_pin_sync (
    .aclk   (aclk),
    .aresetn(aresetn),
    .pin_in ({port_interrupt_pins, request_pin}),
    .pin_out(pins_sync)
  );

  assign req_pin_s  = pins_sync[5:0];
  assign port_pin_s = pins_sync[21:6];

  // sense mode of request pin n, upper bit at the odd position
  function automatic sense_mode_t mode_of(input logic [11:0] s, input int n);
    mode_of = sense_mode_t'({s[2*n+1], s[2*n]});  // R7
  endfunction

  // merge a 32-bit write into a narrow register under byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
    merge16 = old;
    if (st[0]) merge16[7:0] = d[7:0];
    if (st[1]) merge16[15:8] = d[15:8];
  endfunction

  // sense select write merged at full width, upper nibble dropped on purpose
  assign sense_wide = merge16({4'h0, sense_r}, wr.data, wr.strb);

  // ---------------------------------------------------------------
  // port pin gating and group flags
  // ---------------------------------------------------------------
  always_comb begin
    port_req = ~(port_pin_s ^ port_cfg_r.sense) & port_cfg_r.enable;  // R8 R9
    group_lo = |port_req[7:0];   // R10
    group_hi = |port_req[15:8];  // R10
  end

  // register read view: group bits are live, low bits stored
  assign flags_view = {group_lo, group_hi, req_flag_r};  // R2 R3 R4

  // ---------------------------------------------------------------
  // write channel acceptance, either order
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;

  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    wr          = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (aw_held_r && w_held_r) begin
      wr.valid    = 1'b1;
      wr.addr     = aw_addr_r;
      wr.data     = w_data_r;
      wr.strb     = w_strb_r;
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      case (aw_addr_r)
        flags_off, sense_off, port_sense_off, port_en_off, int_stat_off, int_mask_off: begin
          bresp_nxt = resp_okay;
        end
        default: begin
          bresp_nxt = resp_slverr;
        end
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !rvalid_r;
  assign rd_take       = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rd_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = resp_okay;
      case (s_axi_araddr[7:0])
        flags_off:      rdata_nxt = {24'h000000, flags_view};
        sense_off:      rdata_nxt = {20'h00000, sense_r};
        port_sense_off: rdata_nxt = {16'h0000, port_cfg_r.sense};
        port_en_off:    rdata_nxt = {16'h0000, port_cfg_r.enable};
        int_stat_off:   rdata_nxt = {24'h000000, int_stat_r};
        int_mask_off:   rdata_nxt = {24'h000000, int_mask_r};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = resp_slverr;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // request flags, configuration and interrupt status
  // ---------------------------------------------------------------
  always_comb begin
    sense_nxt    = sense_r;
    port_cfg_nxt = port_cfg_r;
    int_mask_nxt = int_mask_r;
    pin_prev_nxt = req_pin_s;
    req_flag_nxt = req_flag_r;
    seen_one_nxt = seen_one_r;
    // a read of the flag register arms the clear of each flag seen as 1
    if (rd_take && s_axi_araddr[7:0] == flags_off) begin
      seen_one_nxt = seen_one_r | req_flag_r;  // R5
    end
    // software clear: only a 0 written to a bit previously read as 1
    if (wr.valid && wr.addr == flags_off && wr.strb[0]) begin
      for (int n = 0; n < num_req; n++) begin
        if (!wr.data[n] && seen_one_r[n]) begin
          req_flag_nxt[n] = 1'b0;  // R5
          seen_one_nxt[n] = 1'b0;
        end
      end
    end
    if (wr.valid && wr.addr == sense_off) begin
      sense_nxt = sense_wide[11:0];
    end
    if (wr.valid && wr.addr == port_sense_off) begin
      port_cfg_nxt.sense = merge16(port_cfg_r.sense, wr.data, wr.strb);
    end
    if (wr.valid && wr.addr == port_en_off) begin
      port_cfg_nxt.enable = merge16(port_cfg_r.enable, wr.data, wr.strb);
    end
    if (wr.valid && wr.addr == int_mask_off && wr.strb[0]) begin
      int_mask_nxt = wr.data[7:0];
    end
    // hardware detection applied last so a set beats a same-cycle clear
    for (int n = 0; n < num_req; n++) begin
      case (mode_of(sense_r, n))
        sense_fall: if (pin_prev_r[n] && !req_pin_s[n]) req_flag_nxt[n] = 1'b1;  // R5
        sense_rise: if (!pin_prev_r[n] && req_pin_s[n]) req_flag_nxt[n] = 1'b1;  // R5
        sense_low:  req_flag_nxt[n] = !req_pin_s[n];  // R6
        sense_high: req_flag_nxt[n] = req_pin_s[n];   // R6
        default:    req_flag_nxt[n] = req_flag_r[n];
      endcase
      if (req_flag_nxt[n] && !req_flag_r[n]) begin
        seen_one_nxt[n] = 1'b0;  // a fresh set needs a fresh read
      end
    end
  end

  // interrupt status: rising of any flag view bit is an event, write one clears
  always_comb begin
    flags_prev_nxt = flags_view;
    int_stat_nxt   = int_stat_r;
    if (wr.valid && wr.addr == int_stat_off && wr.strb[0]) begin
      int_stat_nxt = int_stat_r & ~wr.data[7:0];
    end
    int_stat_nxt = int_stat_nxt | (flags_view & ~flags_prev_r);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_flag_r   <= flags_rst[5:0];  // R1
      flags_prev_r <= flags_rst;       // R1
      sense_r      <= sense_rst;
      port_cfg_r   <= '{sense: port_rst, enable: port_rst};
      int_stat_r   <= int_rst;
      int_mask_r   <= int_rst;
      seen_one_r   <= '0;
      pin_prev_r   <= '0;
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      aw_addr_r    <= '0;
      w_data_r     <= '0;
      w_strb_r     <= '0;
      bvalid_r     <= 1'b0;
      bresp_r      <= resp_okay;
      rvalid_r     <= 1'b0;
      rdata_r      <= '0;
      rresp_r      <= resp_okay;
    end else begin
      req_flag_r   <= req_flag_nxt;
      flags_prev_r <= flags_prev_nxt;
      sense_r      <= sense_nxt;
      port_cfg_r   <= port_cfg_nxt;
      int_stat_r   <= int_stat_nxt;
      int_mask_r   <= int_mask_nxt;
      seen_one_r   <= seen_one_nxt;
      pin_prev_r   <= pin_prev_nxt;
      aw_held_r    <= aw_held_nxt;
      w_held_r     <= w_held_nxt;
      aw_addr_r    <= aw_addr_nxt;
      w_data_r     <= w_data_nxt;
      w_strb_r     <= w_strb_nxt;
      bvalid_r     <= bvalid_nxt;
      bresp_r      <= bresp_nxt;
      rvalid_r     <= rvalid_nxt;
      rdata_r      <= rdata_nxt;
      rresp_r      <= rresp_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;
  assign irq          = |(int_stat_r & int_mask_r);

endmodule

// ---- verif/irq_pin_source.sv ----
// partner: external sources driving the request and port pins
`timescale 1ns/1ns
module irq_pin_source
  import irq_flags_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic [num_req-1:0]  req_cmd,
  input  wire logic [num_port-1:0] port_cmd,
  output logic      [num_req-1:0]  request_pin,
  output logic      [num_port-1:0] port_interrupt_pins
);
  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  // sources hold a level until told otherwise; edges come from level changes
  always_ff @(posedge aclk) begin
    request_pin         <= req_cmd;
    port_interrupt_pins <= port_cmd;
  end
endmodule

// ---- verif/external_irq_request_flags_assertions.sv ----
// checker: bus handshake and flag register assertions
`timescale 1ns/1ns
module external_irq_request_flags_assertions
  import irq_flags_pkg::*;
#(
  parameter int addr_width = 8
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [addr_width-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic                  irq
);
  logic [addr_width-1:0] ar_q;
  // remember the address of the read under way
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_q <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_read_answer: assert property (rd_take |=> s_axi_rvalid) else $error("read answer late");
  a_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write not held off");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read not held off");
  a_flag_width: assert property (s_axi_rvalid && ar_q == flags_off |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("flag register wider than a byte");
  a_unmapped_err: assert property (s_axi_rvalid && ar_q >= 8'h18 |-> s_axi_rresp == resp_slverr && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_irq_reset: assert property ($rose(aresetn) |-> !irq) else $error("interrupt high after reset");
endmodule

bind external_irq_request_flags external_irq_request_flags_assertions #(.addr_width(addr_width)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

// ---- verif/tb_top.sv ----
// testbench: register table, edge and level flags, port groups, interrupt
`timescale 1ns/1ns
module tb_top;
  import irq_flags_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] r;} row_t;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, r;
  logic [5:0]  req_cmd = 6'h00, req_pin;
  logic [15:0] port_cmd = 16'h0000, port_pin;
  int          err_count = 0, cmp_count = 0;
  int          lag = 0;
  row_t rows [5] = '{'{8'h04, 32'hffffffff, 32'h00000fff, resp_okay}, '{8'h08, 32'hffffffff, 32'h0000ffff, resp_okay},
    '{8'h0c, 32'hffffffff, 32'h0000ffff, resp_okay}, '{8'h14, 32'hffffffff, 32'h000000ff, resp_okay},
    '{8'h40, 32'hffffffff, 32'h00000000, resp_slverr}};

  external_irq_request_flags dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .request_pin(req_pin), .port_interrupt_pins(port_pin), .irq(irq));
  irq_pin_source src (.aclk(aclk), .req_cmd(req_cmd), .port_cmd(port_cmd), .request_pin(req_pin),
    .port_interrupt_pins(port_pin));

  // ---------------------------------------------------------------
  // clock, watchdog, checks
  // ---------------------------------------------------------------
  initial begin
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    give_verdict();
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_d(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected data at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_r(input logic [1:0] e, input logic [1:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected resp at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit pa = 1, pw = 1, pb = 1;
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    while (pb) begin
      @(posedge aclk);
      n++;
      if (pa && awready) begin
        awvalid <= 1'b0;
        pa = 0;
      end
      if (pw && wready) begin
        wvalid <= 1'b0;
        pw = 0;
      end
      if (bvalid && bready) begin
        bready <= 1'b0;
        pb = 0;
        rs = bresp;
      end else if (n >= lag) begin
        bready <= 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    bit pa = 1, pr = 1;
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    while (pr) begin
      @(posedge aclk);
      n++;
      if (pa && arready) begin
        arvalid <= 1'b0;
        pa = 0;
      end
      if (rvalid && rready) begin
        rready <= 1'b0;
        pr = 0;
        v = rdata;
        rs = rresp;
      end else if (n >= lag) begin
        rready <= 1'b1;
      end
    end
  endtask
  task automatic wo(input logic [7:0] a, input logic [31:0] v);
    wr(a, v, r);
    chk_r(resp_okay, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk_d(e, d);
    chk_r(resp_okay, r);
  endtask
  task automatic settle();
    repeat (6) @(posedge aclk);
  endtask
  task automatic irq_is(input logic e);
    settle();
    chk_d({31'h0, e}, {31'h0, irq});
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w, r);
      chk_r(rows[i].r, r);
      rd(rows[i].a, d, r);
      chk_d(rows[i].e, d);
      chk_r(rows[i].r, r);
    end
    $display("test table done");
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rc(8'(i * 4), 32'h0);
    $display("test reset done");
    req_cmd <= 6'h3f;
    settle();
    rc(flags_off, 32'h0);
    req_cmd <= 6'h00;
    settle();
    rc(flags_off, 32'h3f);
    rc(int_stat_off, 32'h3f);
    irq_is(1'b0);
    wo(int_mask_off, 32'h1);
    irq_is(1'b1);
    wo(flags_off, 32'h0);
    rc(flags_off, 32'h0);
    wo(int_stat_off, 32'hff);
    irq_is(1'b0);
    wo(sense_off, 32'h555);
    req_cmd <= 6'h3f;
    settle();
    rc(flags_off, 32'h3f);
    wo(flags_off, 32'h0);
    req_cmd <= 6'h00;
    settle();
    rc(flags_off, 32'h0);
    req_cmd <= 6'h3f;
    settle();
    wo(flags_off, 32'h0);
    rc(flags_off, 32'h3f);
    $display("test edge done");
    wo(sense_off, 32'hfff);
    settle();
    rc(flags_off, 32'h3f);
    wo(flags_off, 32'h0);
    rc(flags_off, 32'h3f);
    req_cmd <= 6'h00;
    settle();
    rc(flags_off, 32'h0);
    wo(sense_off, 32'haaa);
    settle();
    rc(flags_off, 32'h3f);
    req_cmd <= 6'h3f;
    settle();
    rc(flags_off, 32'h0);
    $display("test level done");
    port_cmd <= 16'hffff;
    settle();
    rc(flags_off, 32'h0);
    wo(port_en_off, 32'h1);
    rc(flags_off, 32'h0);
    wo(port_sense_off, 32'h1);
    rc(flags_off, 32'h80);
    wo(port_en_off, 32'h8000);
    wo(port_sense_off, 32'h8000);
    rc(flags_off, 32'h40);
    wo(flags_off, 32'h0);
    rc(flags_off, 32'h40);
    port_cmd <= 16'h7fff;
    settle();
    rc(flags_off, 32'h0);
    $display("test group done");
    lag = 3;  // late ready keeps both answers standing
    wo(int_mask_off, 32'h3);
    rc(int_mask_off, 32'h3);
    lag = 0;
    $display("test late ready done");
    give_verdict();
  end
endmodule
